/* design/port_d_e_pin_mux.sv */
// Purpose: port d and port e direction, latches and pin function multiplexing
// Assumes: apb slave, pclk 250 MHz, presetn async active low
// Notes:   pins are split into input, output and output enable
//
// Behaviour
// - port e direction one turns driver off
// - port e direction zero drives output latch
// - port e latch reads back latched value
// - eight independent port e pins, schmitt inputs, ttl in bus or slave mode
// - port e io unless large variant bus mode owns the pins
// - large variant processor modes with bus enabled give port e address high
// - slave enable makes e2..e0 control inputs
// - capture2 select clear routes unit to e7 in microcontroller mode
// - large variant extended mode resets to bus
// - port d pin n: io, bus, slave
// - port d ttl in bus or slave mode
// - only large variant has bus on d
// - slave control works only in microcontroller mode
// - small variant bus control reads zero
// - unimplemented control bits read zero
// - slave control inputs are active low
// - overrides never written into direction registers
`timescale 1ns/1ps
module port_d_e_pin_mux
    import port_de_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic [7:0]  port_d_in,
    output logic      [7:0]  port_d_out,
    output logic      [7:0]  port_d_oe,
    output logic             port_d_ttl,
    input  wire logic [7:0]  port_e_in,
    output logic      [7:0]  port_e_out,
    output logic      [7:0]  port_e_oe,
    output logic             port_e_ttl,
    input  wire logic [15:0] bus_ad_out,
    input  wire logic        bus_ad_drive,
    output logic      [15:0] bus_ad_in,
    input  wire logic [7:0]  slave_data_out,
    input  wire logic        slave_data_drive,
    input  wire logic [2:0]  slave_status,
    output logic      [2:0]  slave_ctrl_n,
    output logic             slave_port_active,
    input  wire logic        capture2_out,
    input  wire logic        capture2_drive,
    output logic             capture2_in,
    output logic             capture2_on_e7
);
    logic [7:0]  d_sync;
    logic [7:0]  e_sync;
    logic [7:0]  port_d_latch, next_port_d_latch;
    logic [7:0]  port_d_dir, next_port_d_dir;
    logic [7:0]  port_e_latch, next_port_e_latch;
    logic [7:0]  port_e_dir, next_port_e_dir;
    logic [7:0]  slave_ctrl, next_slave_ctrl;
    logic [7:0]  bus_ctrl, next_bus_ctrl;
    logic [2:0]  mode_ctrl, next_mode_ctrl;
    logic [31:0] next_prdata;
    logic        next_pready;
    logic        next_pslverr;
    logic [7:0]  next_d_out, next_d_oe, next_e_out, next_e_oe;
    logic [15:0] next_bus_ad_in;
    logic [2:0]  next_slave_ctrl_n;
    logic        next_cap_in, next_cap_on_e7, next_d_ttl, next_e_ttl, next_psp_act;
    logic        large_variant, bus_mode, slave_mode, cap_route, access, mapped;
    logic [1:0]  proc_mode;

    // mode_ctrl bit0 capture2 select, bit1 large variant, bit2 processor mode
    function automatic logic [31:0] widen(input logic [7:0] v);
        return {24'h000000, v};
    endfunction

    function automatic logic [7:0] drive_mux(input logic [7:0] latch,
                                             input logic [7:0] dir);
        return latch & ~dir;
    endfunction

    // pin levels cross into pclk before any logic reads them
    sync_two_flop u_sync_d (
        .pclk     (pclk),
        .presetn  (presetn),
        .async_in (port_d_in),
        .sync_out (d_sync)
    );
    sync_two_flop u_sync_e (
        .pclk     (pclk),
        .presetn  (presetn),
        .async_in (port_e_in),
        .sync_out (e_sync)
    );

    // pin function selection
    always_comb begin
        large_variant = mode_ctrl[BIT_LARGE_VARIANT];
        proc_mode     = {1'b0, mode_ctrl[BIT_PROC_MODE_LO]};
        if (mode_ctrl[BIT_PROC_MODE_LO] && bus_ctrl[BIT_BUS_DISABLE] == 1'b0)
            proc_mode = MODE_EXTENDED;
        if (!mode_ctrl[BIT_PROC_MODE_LO])
            proc_mode = MODE_MICROCTRL;
        // bus owns pins only on the large variant, outside microcontroller mode
        bus_mode   = large_variant && (proc_mode != MODE_MICROCTRL)
                     && !bus_ctrl[BIT_BUS_DISABLE];
        slave_mode = slave_ctrl[BIT_SLAVE_ENABLE] && !bus_mode
                     && (proc_mode == MODE_MICROCTRL);
        cap_route  = !mode_ctrl[BIT_CAPTURE2_SEL] && !bus_mode
                     && (proc_mode == MODE_MICROCTRL);
    end

    // pin drive; overrides act here and never touch the direction registers
    always_comb begin
        next_d_out = port_d_latch;
        next_d_oe  = ~port_d_dir;
        next_e_out = port_e_latch;
        next_e_oe  = ~port_e_dir;
        if (bus_mode) begin
            next_d_out = bus_ad_out[7:0];
            next_d_oe  = {8{bus_ad_drive}};
            next_e_out = bus_ad_out[15:8];
            next_e_oe  = {8{bus_ad_drive}};
        end else begin
            if (slave_mode) begin
                next_d_out = slave_data_out;
                next_d_oe  = {8{slave_data_drive}};
                next_e_oe[2:0] = 3'h0;
            end
            if (cap_route) begin
                next_e_out[7] = capture2_out;
                next_e_oe[7]  = capture2_drive;
            end
        end
        next_d_ttl        = bus_mode || slave_mode;
        next_e_ttl        = bus_mode || slave_mode;
        next_bus_ad_in    = {e_sync, d_sync};
        next_slave_ctrl_n = slave_mode ? e_sync[2:0] : 3'h7;
        next_psp_act      = slave_mode;
        next_cap_in       = e_sync[7];
        next_cap_on_e7    = cap_route;
    end

    // apb register file
    always_comb begin
        access            = psel && penable;
        mapped            = 1'b1;
        next_port_d_latch = port_d_latch;
        next_port_d_dir   = port_d_dir;
        next_port_e_latch = port_e_latch;
        next_port_e_dir   = port_e_dir;
        next_slave_ctrl   = {slave_status, slave_ctrl[4:0]} & (SLAVE_CTRL_MASK | SLAVE_STAT_MASK);
        next_bus_ctrl     = bus_ctrl;
        next_mode_ctrl    = mode_ctrl;
        next_prdata       = 32'h0000_0000;
        unique case (paddr)
            OFS_PORT_D_PINS:  next_prdata = widen(d_sync);
            OFS_PORT_D_LATCH: next_prdata = widen(port_d_latch);
            OFS_PORT_D_DIR:   next_prdata = widen(port_d_dir);
            OFS_PORT_E_PINS:  next_prdata = widen(e_sync);
            OFS_PORT_E_LATCH: next_prdata = widen(port_e_latch);
            OFS_PORT_E_DIR:   next_prdata = widen(port_e_dir);
            OFS_SLAVE_CTRL:   next_prdata = widen(slave_ctrl);
            OFS_BUS_CTRL:     next_prdata = large_variant ? widen(bus_ctrl)
                                                          : 32'h0000_0000;
            OFS_MODE_CTRL:    next_prdata = {28'h0000000, 1'b0, mode_ctrl};
            default:          mapped = 1'b0;
        endcase
        // writes land only at the edge where pready is high, as the master expects
        if (access && pwrite && pready) begin
            unique case (paddr)
                OFS_PORT_D_PINS, OFS_PORT_D_LATCH: next_port_d_latch = pwdata[7:0];
                OFS_PORT_D_DIR:   next_port_d_dir = pwdata[7:0];
                OFS_PORT_E_PINS, OFS_PORT_E_LATCH: next_port_e_latch = pwdata[7:0];
                OFS_PORT_E_DIR:   next_port_e_dir = pwdata[7:0];
                OFS_SLAVE_CTRL:   next_slave_ctrl = (next_slave_ctrl & SLAVE_STAT_MASK)
                                                  | (pwdata[7:0] & SLAVE_CTRL_MASK);
                OFS_BUS_CTRL:     if (large_variant)
                                      next_bus_ctrl = pwdata[7:0] & BUS_CTRL_MASK;
                OFS_MODE_CTRL:    next_mode_ctrl = pwdata[2:0];
                default:          next_mode_ctrl = mode_ctrl;
            endcase
        end
        next_pready  = access && !pready;
        next_pslverr = access && !pready && !mapped;
        if (!(access && !pready))
            next_prdata = 32'h0000_0000;
    end

    // register stage; latches have no reset value of their own beyond a clean start
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            port_d_latch      <= LATCH_RESET;
            port_e_latch      <= LATCH_RESET;
            port_d_dir        <= DIR_RESET;
            port_e_dir        <= DIR_RESET;
            slave_ctrl        <= CTRL_RESET;
            bus_ctrl          <= CTRL_RESET;
            mode_ctrl         <= MODE_CTRL_RESET[2:0];
            prdata            <= 32'h0000_0000;
            pready            <= 1'b0;
            pslverr           <= 1'b0;
            port_d_out        <= 8'h00;
            port_d_oe         <= 8'h00;
            port_e_out        <= 8'h00;
            port_e_oe         <= 8'h00;
            port_d_ttl        <= 1'b0;
            port_e_ttl        <= 1'b0;
            bus_ad_in         <= 16'h0000;
            slave_ctrl_n      <= 3'h7;
            slave_port_active <= 1'b0;
            capture2_in       <= 1'b0;
            capture2_on_e7    <= 1'b0;
        end else begin
            port_d_latch      <= next_port_d_latch;
            port_e_latch      <= next_port_e_latch;
            port_d_dir        <= next_port_d_dir;
            port_e_dir        <= next_port_e_dir;
            slave_ctrl        <= next_slave_ctrl;
            bus_ctrl          <= next_bus_ctrl;
            mode_ctrl         <= next_mode_ctrl;
            prdata            <= next_prdata;
            pready            <= next_pready;
            pslverr           <= next_pslverr;
            port_d_out        <= next_d_out;
            port_d_oe         <= next_d_oe;
            port_e_out        <= next_e_out;
            port_e_oe         <= next_e_oe;
            port_d_ttl        <= next_d_ttl;
            port_e_ttl        <= next_e_ttl;
            bus_ad_in         <= next_bus_ad_in;
            slave_ctrl_n      <= next_slave_ctrl_n;
            slave_port_active <= next_psp_act;
            capture2_in       <= next_cap_in;
            capture2_on_e7    <= next_cap_on_e7;
        end
    end

    // checks on pin drive and register behaviour
    sequence s_e_dir_write;
        psel && penable && pwrite && pready && paddr == OFS_PORT_E_DIR;
    endsequence

    property p_e_input_off;
        @(posedge pclk) disable iff (!presetn)
        (!bus_mode && !slave_mode && !cap_route && port_e_dir[3]) |=> !port_e_oe[3];
    endproperty
    a_e_input_off: assert property (p_e_input_off) else $error("e pin driven as input");

    property p_e_output_on;
        @(posedge pclk) disable iff (!presetn)
        (!bus_mode && !port_e_dir[5]) |=> (port_e_oe[5] && port_e_out[5] == $past(port_e_latch[5]));
    endproperty
    a_e_output_on: assert property (p_e_output_on) else $error("e output not latch");

    property p_e_latch_read;
        @(posedge pclk) disable iff (!presetn)
        (psel && penable && !pwrite && !pready && paddr == OFS_PORT_E_LATCH)
            |=> prdata == widen($past(port_e_latch));
    endproperty
    a_e_latch_read: assert property (p_e_latch_read) else $error("latch readback wrong");

    property p_e_dir_store;
        @(posedge pclk) disable iff (!presetn)
        s_e_dir_write |=> port_e_dir == $past(pwdata[7:0])
            ##1 ($past(bus_mode) || port_e_oe[6] == !$past(port_e_dir[6]));
    endproperty
    a_e_dir_store: assert property (p_e_dir_store) else $error("direction not stored");

    property p_bus_owns;
        @(posedge pclk) disable iff (!presetn)
        bus_mode |=> (port_e_out == $past(bus_ad_out[15:8]) && port_d_ttl);
    endproperty
    a_bus_owns: assert property (p_bus_owns) else $error("bus byte not on e");

    property p_slave_inputs;
        @(posedge pclk) disable iff (!presetn)
        slave_mode |=> (port_e_oe[2:0] == 3'h0 && slave_port_active);
    endproperty
    a_slave_inputs: assert property (p_slave_inputs) else $error("slave controls driven");

    property p_no_override_store;
        @(posedge pclk) disable iff (!presetn)
        (slave_mode && !(psel && penable && pwrite)) |=> $stable(port_e_dir);
    endproperty
    a_no_override_store: assert property (p_no_override_store) else $error("override stored");

    property p_small_reads_zero;
        @(posedge pclk) disable iff (!presetn)
        (!large_variant && psel && penable && !pready && paddr == OFS_BUS_CTRL)
            |=> prdata == 32'h0000_0000;
    endproperty
    a_small_reads_zero: assert property (p_small_reads_zero) else $error("bus ctrl not zero");
endmodule

/* design/port_de_pkg.sv */
// Purpose: shared constants for the port d / port e pin multiplexer
// Assumes: apb byte addresses, one 32-bit word per register
// Notes:   mode and variant encodings are plain codes of this block
package port_de_pkg;
    localparam logic [11:0] OFS_PORT_D_PINS     = 12'h000;
    localparam logic [11:0] OFS_PORT_D_LATCH    = 12'h004;
    localparam logic [11:0] OFS_PORT_D_DIR      = 12'h008;
    localparam logic [11:0] OFS_PORT_E_PINS     = 12'h00C;
    localparam logic [11:0] OFS_PORT_E_LATCH    = 12'h010;
    localparam logic [11:0] OFS_PORT_E_DIR      = 12'h014;
    localparam logic [11:0] OFS_SLAVE_CTRL      = 12'h018;
    localparam logic [11:0] OFS_BUS_CTRL        = 12'h01C;
    localparam logic [11:0] OFS_MODE_CTRL       = 12'h020;
    localparam logic [7:0]  DIR_RESET           = 8'hFF;
    localparam logic [7:0]  LATCH_RESET         = 8'h00;
    localparam logic [7:0]  CTRL_RESET          = 8'h00;
    localparam logic [7:0]  SLAVE_CTRL_MASK     = 8'h10;
    localparam logic [7:0]  SLAVE_STAT_MASK     = 8'hE0;
    localparam logic [7:0]  BUS_CTRL_MASK       = 8'hB3;
    localparam int          BIT_BUS_DISABLE     = 7;
    localparam int          BIT_SLAVE_ENABLE    = 4;
    localparam int          BIT_CAPTURE2_SEL    = 0;
    localparam int          BIT_LARGE_VARIANT   = 1;
    localparam int          BIT_PROC_MODE_LO    = 2;
    localparam logic [1:0]  MODE_MICROCTRL      = 2'h0;
    localparam logic [1:0]  MODE_EXTENDED       = 2'h1;
    localparam logic [1:0]  MODE_MICROPROC      = 2'h2;
    localparam logic [31:0] MODE_CTRL_RESET     = 32'h0000_0001;
endpackage

/* design/sync_two_flop.sv */
// Purpose: two flip-flop synchroniser for an 8-bit group of pin levels
// Assumes: each bit is an independent level, no bus coherence needed
// Notes:   the first stage feeds only the second stage
`timescale 1ns/1ps
module sync_two_flop (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic [7:0] async_in,
    output logic      [7:0] sync_out
);
    logic [7:0] stage_one;
    // first and second stage registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stage_one <= 8'h00;
            sync_out  <= 8'h00;
        end else begin
            stage_one <= async_in;
            sync_out  <= stage_one;
        end
    end
endmodule

/* testbench/pin_board.sv */
// Purpose: far side of ports d and e, host and board wiring
// Assumes: host drives every pin that the device leaves undriven
// Notes:   host levels come from the bench through host_d and host_e
`timescale 1ns/1ps
module pin_board (
    input  wire logic [7:0] port_d_out,
    input  wire logic [7:0] port_d_oe,
    input  wire logic [7:0] port_e_out,
    input  wire logic [7:0] port_e_oe,
    input  wire logic [7:0] host_d,
    input  wire logic [7:0] host_e,
    output logic      [7:0] port_d_in,
    output logic      [7:0] port_e_in
);
    // pin level: device driver wins, otherwise the host level shows
    assign port_d_in = (port_d_oe & port_d_out) | (~port_d_oe & host_d);
    // host strobes e2..e0 active low, device leaves them as inputs
    assign port_e_in = (port_e_oe & port_e_out) | (~port_e_oe & host_e);
endmodule

/* testbench/port_d_e_pin_mux_tb_top.sv */
// Purpose: register and pin tests of the port d / port e multiplexer
// Assumes: apb answer comes when pready is high, pins settle in 4 cycles
// Notes:   the host board model drives all undriven pin levels
`timescale 1ns/1ps
module port_d_e_pin_mux_tb_top;
    import port_de_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [7:0]  port_d_in, port_d_out, port_d_oe, port_e_in, port_e_out, port_e_oe;
    logic [7:0]  host_d, host_e, slave_data_out;
    logic        port_d_ttl, port_e_ttl, bus_ad_drive, slave_data_drive, slave_port_active;
    logic        capture2_out, capture2_drive, capture2_in, capture2_on_e7;
    logic [15:0] bus_ad_out, bus_ad_in;
    logic [2:0]  slave_status, slave_ctrl_n;
    int          error_cnt, total_checks;

    port_d_e_pin_mux port_d_e_pin_mux_inst (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .port_d_in, .port_d_out, .port_d_oe, .port_d_ttl, .port_e_in,
        .port_e_out, .port_e_oe, .port_e_ttl, .bus_ad_out, .bus_ad_drive, .bus_ad_in,
        .slave_data_out, .slave_data_drive, .slave_status, .slave_ctrl_n,
        .slave_port_active, .capture2_out, .capture2_drive, .capture2_in, .capture2_on_e7
    );
    pin_board pin_board_inst (
        .port_d_out, .port_d_oe, .port_e_out, .port_e_oe, .host_d, .host_e,
        .port_d_in, .port_e_in
    );

    // 250 MHz clock
    always #2 pclk = ~pclk;

    // one comparison, counted and reported at once
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // one apb transfer, held until pready is sampled high at a rising edge;
    // only the watchdog ends a wait, one idle edge follows the release
    task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic rchk(input logic [11:0] a, input logic [7:0] e, input logic e_err);
        apb(1'b0, a, 8'h00);
        chk(rd, {24'h0, e});
        chk({31'h0, err}, {31'h0, e_err});
    endtask

    // driven pins only: oe and out masked by oe, d then e
    task automatic pins(input logic [7:0] doe, dout, eoe, eout);
        chk({port_d_oe, port_d_out & port_d_oe, port_e_oe, port_e_out & port_e_oe},
            {doe, dout & doe, eoe, eout & eoe});
    endtask

    task automatic settle();
        repeat (4) @(posedge pclk);
    endtask

    task automatic test_done();
        $display("checks=%0d mismatches=%0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // watchdog against a hung handshake
    initial begin
        #20000;
        error_cnt++;
        test_done();
    end

    // main sequence
    initial begin
        pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
        host_d = 8'h5A; host_e = 8'hFF; bus_ad_out = 16'hC3A5; bus_ad_drive = 1;
        slave_data_out = 8'h00; slave_data_drive = 0; slave_status = 3'b101;
        capture2_out = 0; capture2_drive = 0; error_cnt = 0; total_checks = 0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        // reset values, unmapped place
        pins(8'h00, 8'h00, 8'h00, 8'h00);
        rchk(OFS_PORT_D_DIR, DIR_RESET, 1'b0);
        rchk(OFS_PORT_E_DIR, 8'hFF, 1'b0);
        rchk(OFS_MODE_CTRL, MODE_CTRL_RESET[7:0], 1'b0);
        rchk(OFS_BUS_CTRL, 8'h00, 1'b0);
        rchk(12'h024, 8'h00, 1'b1);
        chk({29'h0, slave_ctrl_n}, 32'h7);
        $display("test reset done");
        // large variant, extended mode: bus owns both ports from reset
        apb(1'b1, OFS_MODE_CTRL, 8'h06);
        apb(1'b1, OFS_SLAVE_CTRL, 8'h10);
        settle();
        pins(8'hFF, 8'hA5, 8'hFF, 8'hC3);
        chk({29'h0, port_d_ttl, port_e_ttl, capture2_on_e7}, 32'h6);
        chk({16'h0, bus_ad_in}, 32'hC3A5);
        chk({28'h0, slave_port_active, slave_ctrl_n}, 32'h7);
        apb(1'b1, OFS_BUS_CTRL, 8'hFF);
        rchk(OFS_BUS_CTRL, BUS_CTRL_MASK, 1'b0);
        settle();
        pins(8'h00, 8'h00, 8'h00, 8'h00);
        chk({30'h0, port_d_ttl, port_e_ttl}, 32'h0);
        apb(1'b1, OFS_SLAVE_CTRL, 8'h00);
        $display("test bus mode done");
        // small variant: bus control reads zero, no bus on the pins
        apb(1'b1, OFS_BUS_CTRL, 8'h00);
        apb(1'b1, OFS_MODE_CTRL, 8'h04);
        settle();
        rchk(OFS_BUS_CTRL, 8'h00, 1'b0);
        pins(8'h00, 8'h00, 8'h00, 8'h00);
        $display("test small variant done");
        // plain io on both ports
        apb(1'b1, OFS_MODE_CTRL, 8'h05);
        apb(1'b1, OFS_PORT_E_LATCH, 8'hA5);
        apb(1'b1, OFS_PORT_E_DIR, 8'h0F);
        apb(1'b1, OFS_PORT_D_PINS, 8'h3C);
        apb(1'b1, OFS_PORT_D_DIR, 8'h00);
        settle();
        pins(8'hFF, 8'h3C, 8'hF0, 8'hA5);
        rchk(OFS_PORT_E_LATCH, 8'hA5, 1'b0);
        rchk(OFS_PORT_E_PINS, 8'hAF, 1'b0);
        rchk(OFS_PORT_D_LATCH, 8'h3C, 1'b0);
        $display("test io done");
        // slave port in microcontroller mode, host selects and reads
        apb(1'b1, OFS_MODE_CTRL, 8'h01);
        apb(1'b1, OFS_PORT_E_DIR, 8'h07);
        host_e <= 8'hFA;
        slave_data_out <= 8'h96;
        slave_data_drive <= 1'b1;
        apb(1'b1, OFS_SLAVE_CTRL, 8'h10);
        settle();
        pins(8'hFF, 8'h96, 8'hF8, 8'hA5);
        chk({28'h0, slave_port_active, slave_ctrl_n}, 32'hA);
        chk({30'h0, port_d_ttl, port_e_ttl}, 32'h3);
        rchk(OFS_SLAVE_CTRL, 8'hB0, 1'b0);
        rchk(OFS_PORT_E_DIR, 8'h07, 1'b0);
        slave_data_drive <= 1'b0;
        apb(1'b1, OFS_SLAVE_CTRL, 8'h00);
        $display("test slave port done");
        // capture unit on e7 when its select is clear
        capture2_out <= 1'b1;
        capture2_drive <= 1'b1;
        apb(1'b1, OFS_MODE_CTRL, 8'h00);
        settle();
        chk({28'h0, capture2_on_e7, port_e_oe[7], port_e_out[7], capture2_in}, 32'hF);
        rchk(OFS_PORT_E_DIR, 8'h07, 1'b0);
        apb(1'b1, OFS_MODE_CTRL, 8'h01);
        settle();
        chk({31'h0, capture2_on_e7}, 32'h0);
        $display("test capture pin done");
        // second reset in mid-run returns every pin to input
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        pins(8'h00, 8'h00, 8'h00, 8'h00);
        rchk(OFS_PORT_D_DIR, 8'hFF, 1'b0);
        $display("test second reset done");
        test_done();
    end
endmodule
